/* File: design/npe_pkg.sv */
package npe_pkg;

   // ***********************************************
   // Commands
   // ***********************************************
   typedef enum logic [2:0] {
      CMD_PROGRAM,
      CMD_ROW_PROGRAM,
      CMD_SECTOR_ERASE,
      CMD_MASS_ERASE,
      CMD_BLANK_CHECK
   } npe_cmd_e;

   // ***********************************************
   // Widths and array constants
   // ***********************************************
   localparam int unsigned DATA_W          = 16;
   localparam int unsigned ADDR_W          = 16;
   localparam int unsigned DIV_W           = 8;
   localparam logic [15:0] BLANK_WORD      = 16'hffff;
   localparam int unsigned FLASH_SECTOR_B  = 1024;
   localparam int unsigned EE_SECTOR_B     = 4;
   localparam int unsigned FLASH_BLK_WORDS = 65536;
   localparam int unsigned EE_BLK_WORDS    = 1024;

   // ***********************************************
   // Clock rates in kHz
   // ***********************************************
   localparam int unsigned MCLK_KHZ        = 250000;
   localparam int unsigned OP_KHZ_MIN      = 150;
   localparam int unsigned OP_KHZ_MAX      = 200;
   localparam int unsigned BUS_KHZ_MIN     = 1000;
   localparam int unsigned OSC_KHZ_MIN     = 500;

   // ***********************************************
   // Operation timing counts
   // ***********************************************
   localparam int unsigned SWPGM_OP_TICKS  = 9;
   localparam int unsigned SWPGM_BUS_CYC   = 25;
   localparam int unsigned BWPGM_OP_TICKS  = 4;
   localparam int unsigned BWPGM_BUS_CYC   = 9;
   localparam int unsigned ROW_WORDS       = 64;
   localparam int unsigned ROW_TAIL_WORDS  = 63;
   localparam int unsigned ERA_OP_TICKS    = 4000;
   localparam int unsigned MASS_OP_TICKS   = 20000;
   localparam int unsigned BLANK_SETUP_CYC = 10;

endpackage : npe_pkg

/* File: design/npe_if.sv */
`timescale 1ns/10ps
interface npe_if;
   logic                           req_valid;
   logic                           req_ready;
   npe_pkg::npe_cmd_e              req_cmd;
   logic                           req_array;
   logic [npe_pkg::ADDR_W-1:0]     req_addr;
   logic [npe_pkg::DATA_W-1:0]     req_data;
   logic                           done;
   logic                           fail;
   logic                           busy;

   modport dev (
      input  req_valid,
      output req_ready,
      input  req_cmd,
      input  req_array,
      input  req_addr,
      input  req_data,
      output done,
      output fail,
      output busy
   );

   modport hst (
      output req_valid,
      input  req_ready,
      output req_cmd,
      output req_array,
      output req_addr,
      output req_data,
      input  done,
      input  fail,
      input  busy
   );
endinterface : npe_if

/* File: design/npe_host.sv */
`timescale 1ns/10ps
module npe_host #(
   parameter int unsigned BUS_KHZ = npe_pkg::MCLK_KHZ,
   parameter int unsigned OSC_KHZ = 4000
) (
   input  wire logic                        mclk,
   input  wire logic                        rst,
   input  wire logic                        ce,
   npe_if.hst                               nvm,
   input  wire logic                        usr_valid,
   output logic                             usr_ready,
   input  wire npe_pkg::npe_cmd_e           usr_cmd,
   input  wire logic                        usr_array,
   input  wire logic [npe_pkg::ADDR_W-1:0]  usr_addr,
   input  wire logic [npe_pkg::DATA_W-1:0]  usr_data,
   output logic                             usr_done,
   output logic                             usr_fail,
   output logic                             usr_busy
);

   // ***********************************************
   // Clock conditions
   // ***********************************************
   // bus clock floor
   localparam bit BUS_OK = (BUS_KHZ >= npe_pkg::BUS_KHZ_MIN);
   localparam bit OSC_OK = (OSC_KHZ >= npe_pkg::OSC_KHZ_MIN);

   logic                        slot_q;
   npe_pkg::npe_cmd_e           cmd_q;
   logic                        array_q;
   logic [npe_pkg::ADDR_W-1:0]  addr_q;
   logic [npe_pkg::DATA_W-1:0]  data_q;
   logic                        take;
   logic                        allowed;

   // Blank check neither programs nor erases, so it needs no clock floor
   assign allowed   = (usr_cmd == npe_pkg::CMD_BLANK_CHECK) || (BUS_OK && OSC_OK);
   // one word staged keeps the pipeline filled
   assign usr_ready = allowed && (!slot_q || nvm.req_ready);
   assign take      = ce && usr_valid && usr_ready;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         slot_q  <= 1'b0;
         cmd_q   <= npe_pkg::CMD_PROGRAM;
         array_q <= 1'b0;
         addr_q  <= '0;
         data_q  <= '0;
      end else if (ce) begin
         if (take) begin
            slot_q  <= 1'b1;
            cmd_q   <= usr_cmd;
            array_q <= usr_array;
            addr_q  <= usr_addr;
            data_q  <= usr_data;
         end else if (nvm.req_ready) begin
            slot_q  <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         usr_done <= 1'b0;
         usr_fail <= 1'b0;
      end else if (ce) begin
         usr_done <= nvm.done;
         usr_fail <= nvm.done ? nvm.fail : usr_fail;
      end
   end

   assign usr_busy      = slot_q || nvm.busy;
   assign nvm.req_valid = slot_q;
   assign nvm.req_cmd   = cmd_q;
   assign nvm.req_array = array_q;
   assign nvm.req_addr  = addr_q;
   assign nvm.req_data  = data_q;

endmodule : npe_host

/* File: design/npe_dev.sv */
`timescale 1ns/10ps
module npe_dev #(
   parameter int unsigned ERA_TICKS   = npe_pkg::ERA_OP_TICKS,
   parameter int unsigned MASS_TICKS  = npe_pkg::MASS_OP_TICKS,
   parameter int unsigned FLASH_WORDS = npe_pkg::FLASH_BLK_WORDS,
   parameter int unsigned EE_WORDS    = npe_pkg::EE_BLK_WORDS
) (
   input  wire logic                        mclk,
   input  wire logic                        rst,
   input  wire logic                        ce,
   npe_if.dev                               nvm,
   input  wire logic                        osc_in,
   input  wire logic [npe_pkg::DIV_W-1:0]   flash_op_clock_divider,
   input  wire logic [npe_pkg::DIV_W-1:0]   eeprom_op_clock_divider,
   output logic [npe_pkg::ADDR_W-1:0]       arr_addr,
   output logic [npe_pkg::DATA_W-1:0]       arr_wdata,
   output npe_pkg::npe_cmd_e                arr_cmd,
   output logic                             arr_sel,
   output logic                             arr_strobe,
   input  wire logic [npe_pkg::DATA_W-1:0]  arr_rdata
);

   localparam int unsigned TW = 15;
   localparam logic [7:0]  BUS_SW   = 8'(npe_pkg::SWPGM_BUS_CYC);
   localparam logic [7:0]  BUS_BW   = 8'(npe_pkg::BWPGM_BUS_CYC);
   localparam logic [7:0]  BUS_BLK  = 8'(npe_pkg::BLANK_SETUP_CYC);
   localparam logic [TW-1:0] TK_SW  = TW'(npe_pkg::SWPGM_OP_TICKS);
   localparam logic [TW-1:0] TK_BW  = TW'(npe_pkg::BWPGM_OP_TICKS);
   localparam logic [TW-1:0] TK_ERA = TW'(ERA_TICKS);
   localparam logic [TW-1:0] TK_MAS = TW'(MASS_TICKS);
   localparam logic [6:0]  ROW_MAX  = 7'(npe_pkg::ROW_WORDS);
   localparam logic [npe_pkg::ADDR_W-1:0] LAST_FL = npe_pkg::ADDR_W'(FLASH_WORDS - 1);
   localparam logic [npe_pkg::ADDR_W-1:0] LAST_EE = npe_pkg::ADDR_W'(EE_WORDS - 1);

   typedef enum logic [1:0] {S_IDLE, S_BUS, S_OP, S_BLANK} npe_state_e;

   npe_state_e                  state_q;
   npe_pkg::npe_cmd_e           cmd_q;
   logic                        arr_q;
   logic [npe_pkg::ADDR_W-1:0]  addr_q;
   logic [npe_pkg::DATA_W-1:0]  data_q;
   logic [7:0]                  bus_cnt_q;
   logic [TW-1:0]               tick_cnt_q;
   logic [6:0]                  word_cnt_q;
   logic                        pend_q;
   logic [npe_pkg::ADDR_W-1:0]  pend_addr_q;
   logic [npe_pkg::DATA_W-1:0]  pend_data_q;
   logic                        done_q;
   logic                        fail_q;
   logic                        strobe_q;
   logic [2:0]                  osc_sync_q;
   logic [npe_pkg::DIV_W-1:0]   div_cnt_q;
   logic [npe_pkg::DIV_W-1:0]   div_sel;
   logic                        osc_rise;
   logic                        op_tick;
   logic                        row_mode;
   logic                        accept;
   logic                        pipe_take;
   logic                        word_end;
   logic                        blank_hit;
   logic                        blank_last;

   // ***********************************************
   // Operation clock
   // ***********************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         osc_sync_q <= 3'h0;
      end else if (ce) begin
         osc_sync_q <= {osc_sync_q[1:0], osc_in};
      end
   end

   // Edge taken between second and third stage, never on the first
   assign osc_rise = osc_sync_q[1] && !osc_sync_q[2];
   assign div_sel  = arr_q ? eeprom_op_clock_divider : flash_op_clock_divider;
   // ratio used as given, never range checked
   assign op_tick  = osc_rise && (div_cnt_q == div_sel);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_cnt_q <= '0;
      end else if (ce) begin
         // Restart per op phase; the first tick comes on the next matching rise, so it can fall short of a full period
         if (state_q != S_OP || op_tick) begin
            div_cnt_q <= '0;
         end else if (osc_rise) begin
            div_cnt_q <= div_cnt_q + 1'b1;
         end
      end
   end

   // ***********************************************
   // Request acceptance
   // ***********************************************
   // burst only when the target is flash
   assign row_mode  = (cmd_q == npe_pkg::CMD_ROW_PROGRAM) && !arr_q;
   // next word accepted while the current one runs
   assign pipe_take = (state_q == S_BUS || state_q == S_OP) && row_mode && !pend_q
                      && (word_cnt_q < ROW_MAX)
                      && (nvm.req_cmd == npe_pkg::CMD_ROW_PROGRAM) && !nvm.req_array;
   assign nvm.req_ready = (state_q == S_IDLE) || pipe_take;
   assign accept        = ce && nvm.req_valid && (state_q == S_IDLE);
   assign word_end      = (state_q == S_OP) && op_tick && (tick_cnt_q == TW'(1));
   assign blank_hit     = (arr_rdata != npe_pkg::BLANK_WORD);
   assign blank_last    = (addr_q == (arr_q ? LAST_EE : LAST_FL));

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pend_q      <= 1'b0;
         pend_addr_q <= '0;
         pend_data_q <= '0;
      end else if (ce) begin
         if (nvm.req_valid && pipe_take) begin
            pend_q      <= 1'b1;
            pend_addr_q <= nvm.req_addr;
            pend_data_q <= nvm.req_data;
         end else if (word_end) begin
            pend_q      <= 1'b0;
         end
      end
   end

   // ***********************************************
   // Sequencer
   // ***********************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q    <= S_IDLE;
         cmd_q      <= npe_pkg::CMD_PROGRAM;
         arr_q      <= 1'b0;
         addr_q     <= '0;
         data_q     <= '0;
         bus_cnt_q  <= '0;
         tick_cnt_q <= '0;
         word_cnt_q <= '0;
      end else if (ce) begin
         unique case (state_q)
            S_IDLE: begin
               if (accept) begin
                  cmd_q      <= nvm.req_cmd;
                  arr_q      <= nvm.req_array;
                  data_q     <= nvm.req_data;
                  word_cnt_q <= 7'h01;
                  addr_q     <= nvm.req_addr;
                  unique case (nvm.req_cmd)
                     npe_pkg::CMD_PROGRAM, npe_pkg::CMD_ROW_PROGRAM: begin
                        // first word at single word timing
                        bus_cnt_q  <= BUS_SW;
                        tick_cnt_q <= TK_SW;
                        state_q    <= S_BUS;
                     end
                     npe_pkg::CMD_SECTOR_ERASE: begin
                        tick_cnt_q <= TK_ERA;
                        state_q    <= S_OP;
                     end
                     npe_pkg::CMD_MASS_ERASE: begin
                        tick_cnt_q <= TK_MAS;
                        state_q    <= S_OP;
                     end
                     npe_pkg::CMD_BLANK_CHECK: begin
                        bus_cnt_q  <= BUS_BLK;
                        addr_q     <= '0;
                        state_q    <= S_BUS;
                     end
                  endcase
               end
            end
            S_BUS: begin
               if (bus_cnt_q == 8'h01) begin
                  state_q <= (cmd_q == npe_pkg::CMD_BLANK_CHECK) ? S_BLANK : S_OP;
               end
               bus_cnt_q <= bus_cnt_q - 8'h01;
            end
            S_OP: begin
               if (op_tick) begin
                  tick_cnt_q <= tick_cnt_q - TW'(1);
               end
               if (word_end) begin
                  // row continues with burst word times
                  if (row_mode && pend_q) begin
                     bus_cnt_q  <= BUS_BW;
                     tick_cnt_q <= TK_BW;
                     addr_q     <= pend_addr_q;
                     data_q     <= pend_data_q;
                     word_cnt_q <= word_cnt_q + 7'h01;
                     state_q    <= S_BUS;
                  end else begin
                     state_q    <= S_IDLE;
                  end
               end
            end
            S_BLANK: begin
               if (blank_hit || blank_last) begin
                  state_q <= S_IDLE;
               end else begin
                  addr_q  <= addr_q + 1'b1;
               end
            end
         endcase
      end
   end

   // ***********************************************
   // Completion and array strobes
   // ***********************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         done_q   <= 1'b0;
         fail_q   <= 1'b0;
         strobe_q <= 1'b0;
      end else if (ce) begin
         strobe_q <= word_end;
         done_q   <= (word_end && !(row_mode && pend_q))
                     || (state_q == S_BLANK && (blank_hit || blank_last));
         // Fail moves with done, except a row word handing over to a pending word also clears it; a running scan keeps the last verdict
         if (state_q == S_BLANK && (blank_hit || blank_last)) begin
            fail_q <= blank_hit;
         end else if (word_end) begin
            fail_q <= 1'b0;
         end
      end
   end

   assign nvm.done   = done_q;
   assign nvm.fail   = fail_q;
   assign nvm.busy   = (state_q != S_IDLE);
   assign arr_addr   = addr_q;
   assign arr_wdata  = data_q;
   assign arr_cmd    = cmd_q;
   assign arr_sel    = arr_q;
   assign arr_strobe = strobe_q;

endmodule : npe_dev

/* File: tb/npe_properties.sv */
`timescale 1ns/10ps
module npe_properties #(
   parameter int unsigned ERA_TICKS  = 20,
   parameter int unsigned MASS_TICKS = 50,
   parameter int unsigned WORDS      = 16
) (
   input wire logic                       mclk,
   input wire logic                       rst,
   input wire logic                       req_valid,
   input wire logic                       req_ready,
   input wire npe_pkg::npe_cmd_e          req_cmd,
   input wire logic                       req_array,
   input wire logic [npe_pkg::ADDR_W-1:0] req_addr,
   input wire logic [npe_pkg::DATA_W-1:0] req_data,
   input wire logic                       done,
   input wire logic                       fail,
   input wire logic                       busy
);
   localparam int unsigned SW_MIN  = npe_pkg::SWPGM_BUS_CYC + npe_pkg::SWPGM_OP_TICKS;
   localparam int unsigned BW_MIN  = npe_pkg::BWPGM_BUS_CYC + npe_pkg::BWPGM_OP_TICKS;
   localparam int unsigned BLK_MIN = npe_pkg::BLANK_SETUP_CYC + 1;

   int unsigned       cnt_q;
   int unsigned       words_q;
   npe_pkg::npe_cmd_e cmd_q;
   logic              arr_q;

   // ***********************************************
   // Length of the running command
   // ***********************************************
   // Op ticks last at least one cycle, so cycle counts give safe lower bounds
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q   <= 0;
         words_q <= 0;
         cmd_q   <= npe_pkg::CMD_PROGRAM;
         arr_q   <= 1'b0;
      end else if (req_valid && req_ready && !busy) begin
         cnt_q   <= 1;
         words_q <= 1;
         cmd_q   <= req_cmd;
         arr_q   <= req_array;
      end else begin
         cnt_q   <= busy ? cnt_q + 1 : cnt_q;
         words_q <= (req_valid && req_ready) ? words_q + 1 : words_q;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_take;
      req_valid && req_ready && !busy;
   endsequence
   sequence s_end(npe_pkg::npe_cmd_e c);
      done && cmd_q == c;
   endsequence

   chk_take_busy: assert property (s_take |=> busy)
      else $error("busy missing after take");
   chk_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
   chk_busy_end: assert property ($fell(busy) |-> done)
      else $error("busy fell without done");
   chk_idle_ready: assert property (!busy |-> req_ready)
      else $error("idle sequencer refuses");
   chk_fail_done: assert property ($changed(fail) |-> done)
      else $error("fail moved without done");
   chk_cont_flash: assert property (
      busy && req_ready |-> cmd_q == npe_pkg::CMD_ROW_PROGRAM && !arr_q)
      else $error("continuation outside flash row");
   chk_cont_cmd: assert property (
      busy && req_ready |-> req_cmd == npe_pkg::CMD_ROW_PROGRAM && !req_array)
      else $error("continuation of wrong command");
   chk_row_limit: assert property (busy && req_ready |-> words_q < npe_pkg::ROW_WORDS)
      else $error("row took too many words");
   chk_prog_len: assert property (s_end(npe_pkg::CMD_PROGRAM) |-> cnt_q >= SW_MIN)
      else $error("program too short");
   chk_row_len: assert property (
      s_end(npe_pkg::CMD_ROW_PROGRAM) |-> cnt_q >= SW_MIN + (words_q - 1) * BW_MIN)
      else $error("row too short");
   chk_erase_len: assert property (s_end(npe_pkg::CMD_SECTOR_ERASE) |-> cnt_q >= ERA_TICKS)
      else $error("sector erase too short");
   chk_mass_len: assert property (s_end(npe_pkg::CMD_MASS_ERASE) |-> cnt_q >= MASS_TICKS)
      else $error("mass erase too short");
   chk_blank_len: assert property (
      s_end(npe_pkg::CMD_BLANK_CHECK) |-> cnt_q >= BLK_MIN && cnt_q <= WORDS + BLK_MIN + 3)
      else $error("blank check length out of range");
endmodule : npe_properties

/* File: tb/nvm_program_erase_timing_bench.sv */
`timescale 1ns/10ps
module nvm_program_erase_timing_bench;
   localparam int ERA = 20, MASS = 50, FW = 16, EW = 8;
   // Oscillator period in mclk cycles; far above the legal op rate on purpose
   localparam int P = 6;
   logic              mclk = 1'b0, rst = 1'b1, ce = 1'b1, osc_in = 1'b0;
   logic              usr_valid = 1'b0, usr_array = 1'b0;
   npe_pkg::npe_cmd_e usr_cmd = npe_pkg::CMD_PROGRAM;
   logic [15:0]       usr_addr = 16'h0000, usr_data = 16'h0000, arr_addr, arr_rdata;
   logic [7:0]        flash_op_clock_divider = 8'h00, eeprom_op_clock_divider = 8'h01;
   logic              usr_ready, usr_done, usr_fail, usr_busy;
   int                error_cnt = 0, samples_checked = 0, bad_addr = -1, osc_cnt = 0;
   int                cyc = 0, nacc = 0, q_dur[$], q_acc[$];
   int                n_col = 0, n_udone = 0;

   npe_if nvm();
   npe_host i_npe_host (.mclk, .rst, .ce, .nvm(nvm.hst), .usr_valid, .usr_ready, .usr_cmd,
      .usr_array, .usr_addr, .usr_data, .usr_done, .usr_fail, .usr_busy);
   npe_dev #(.ERA_TICKS(ERA), .MASS_TICKS(MASS), .FLASH_WORDS(FW), .EE_WORDS(EW)) i_npe_dev (
      .mclk, .rst, .ce, .nvm(nvm.dev), .osc_in, .flash_op_clock_divider,
      .eeprom_op_clock_divider, .arr_addr, .arr_wdata(), .arr_cmd(), .arr_sel(),
      .arr_strobe(), .arr_rdata);
   npe_properties #(.ERA_TICKS(ERA), .MASS_TICKS(MASS), .WORDS(FW)) i_npe_properties (
      .mclk(mclk), .rst(rst), .req_valid(nvm.req_valid), .req_ready(nvm.req_ready),
      .req_cmd(nvm.req_cmd), .req_array(nvm.req_array), .req_addr(nvm.req_addr),
      .req_data(nvm.req_data), .done(nvm.done), .fail(nvm.fail), .busy(nvm.busy));

   // ***********************************************
   // Clock, oscillator, array and monitor
   // ***********************************************
   always #2 mclk = ~mclk;
   always @(negedge mclk) begin
      osc_cnt <= (osc_cnt + 1) % P;
      osc_in  <= (osc_cnt < P / 2);
   end
   // One word at bad_addr is non-blank; -1 leaves the array erased
   assign arr_rdata = (int'(arr_addr) == bad_addr) ? 16'h0000 : 16'hffff;
   // Results are queued so back-to-back commands are never missed
   always @(posedge mclk) begin
      if (!rst) begin
         cyc++;
         if (usr_done) n_udone++;
         if (nvm.done) begin
            q_dur.push_back(cyc);
            q_acc.push_back(nacc);
         end
         if (nvm.req_valid && nvm.req_ready && !nvm.busy) begin
            cyc = 0;
            nacc = 0;
         end else if (nvm.req_valid && nvm.req_ready) begin
            nacc++;
         end
      end
   end

   // ***********************************************
   // Tasks
   // ***********************************************
   function automatic int lo_t(int b, int k, int t);
      return b + (k - 1) * t + 1;
   endfunction : lo_t
   function automatic int hi_t(int b, int k, int t);
      return b + k * t + 4;
   endfunction : hi_t
   task automatic chk(string what, int lo, int hi, int seen);
      samples_checked++;
      if (seen < lo || seen > hi) begin
         error_cnt++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, seen);
      end
   endtask : chk
   task automatic chk_bit(string what, logic e, logic s);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %b seen %b", what, e, s);
      end
   endtask : chk_bit
   task automatic send(npe_pkg::npe_cmd_e c, logic a, int n);
      for (int i = 0; i < n; i++) begin
         @(negedge mclk);
         usr_valid = 1'b1;
         usr_cmd = c;
         usr_array = a;
         usr_addr = 16'($urandom);
         usr_data = 16'($urandom);
         for (int w = 0; w < 30000 && !usr_ready; w++) @(negedge mclk);
         if (!usr_ready) begin
            error_cnt++;
            $display("MISMATCH usr_ready expected 1 seen 0");
         end
         @(posedge mclk);
      end
      @(negedge mclk);
      usr_valid = 1'b0;
   endtask : send
   task automatic collect(string what, int lo, int hi, int eacc, logic efail);
      n_col++;
      for (int w = 0; w < 30000 && q_dur.size() == 0; w++) @(negedge mclk);
      if (q_dur.size() == 0) begin
         error_cnt++;
         $display("MISMATCH %s expected done seen none", what);
      end else begin
         chk({what, " cycles"}, lo, hi, q_dur.pop_front());
         chk({what, " words"}, eacc, eacc, q_acc.pop_front());
      end
      repeat (3) @(negedge mclk);
      chk_bit({what, " fail"}, efail, usr_fail);
      $display("test %s ended", what);
   endtask : collect
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   // ***********************************************
   // Sequence
   // ***********************************************
   initial begin
      #200000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      void'($urandom(65));
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      bad_addr = $urandom_range(FW - 1);
      send(npe_pkg::CMD_BLANK_CHECK, 1'b0, 1);
      collect("blank_hit", lo_t(10, bad_addr + 1, 1), hi_t(10, bad_addr + 1, 1), 0, 1'b1);
      bad_addr = -1;
      send(npe_pkg::CMD_PROGRAM, 1'b0, 1);
      collect("prog_flash", lo_t(25, 9, P), hi_t(25, 9, P), 0, 1'b0);
      send(npe_pkg::CMD_PROGRAM, 1'b1, 1);
      collect("prog_eeprom", lo_t(25, 9, 2 * P), hi_t(25, 9, 2 * P), 0, 1'b0);
      send(npe_pkg::CMD_BLANK_CHECK, 1'b1, 1);
      collect("blank_clean", lo_t(10, EW, 1), hi_t(10, EW, 1), 0, 1'b0);
      // A 65th word must wait and start a fresh row
      send(npe_pkg::CMD_ROW_PROGRAM, 1'b0, 65);
      collect("row_full", lo_t(25, 9, P) + 63 * lo_t(9, 4, P),
              hi_t(25, 9, P) + 63 * hi_t(9, 4, P), 63, 1'b0);
      collect("row_spill", lo_t(25, 9, P), hi_t(25, 9, P), 0, 1'b0);
      send(npe_pkg::CMD_ROW_PROGRAM, 1'b1, 3);
      repeat (3) collect("row_eeprom", lo_t(25, 9, 2 * P), hi_t(25, 9, 2 * P), 0, 1'b0);
      for (int a = 0; a < 2; a++) begin
         send(npe_pkg::CMD_SECTOR_ERASE, a[0], 1);
         collect("sector", lo_t(0, ERA, P * (a + 1)), hi_t(0, ERA, P * (a + 1)), 0, 1'b0);
         send(npe_pkg::CMD_MASS_ERASE, a[0], 1);
         collect("mass", lo_t(0, MASS, P * (a + 1)), hi_t(0, MASS, P * (a + 1)), 0, 1'b0);
      end
      // Freezing for whole oscillator periods only shifts the end
      send(npe_pkg::CMD_SECTOR_ERASE, 1'b0, 1);
      repeat (20) @(negedge mclk);
      ce = 1'b0;
      repeat (5 * P) @(negedge mclk);
      ce = 1'b1;
      collect("freeze", lo_t(5 * P, ERA, P), hi_t(5 * P, ERA, P), 0, 1'b0);
      chk("usr_done pulses", n_col, n_col, n_udone);
      chk_bit("usr_busy idle", 1'b0, usr_busy);
      report_and_stop();
   end
endmodule : nvm_program_erase_timing_bench
